// ### hw/usw_top.sv
/*
  Synchronous master transmitter with edge wake-up, AXI4-Lite slave.
  Assumes sleepMode comes from logic on ref_clk and that both serial
  lines are resolved outside from their output enables.
*/
`timescale 1ns/1ps
module usw_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Power state
  input  wire logic              sleepMode,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // AXI4-Lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  // AXI4-Lite read data
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Serial clock line (transmit pin)
  input  wire logic              serialClockLineIn,
  output logic                   serialClockLineOut,
  output logic                   serialClockLineOe_n,
  // Serial data line (receive pin)
  input  wire logic              serialDataLineIn,
  output logic                   serialDataLineOut,
  output logic                   serialDataLineOe_n,
  // Processor requests
  output logic                   txIrq,
  output logic                   rxIrq
);

  // ****************************************
  // Parameter check
  // ****************************************
  if (ADDR_W < 8 || ADDR_W > 32)
  begin : gBadAddr
    $error("ADDR_W must be 8 to 32");
  end

  // Mapped-address decode, shared by both bus paths
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    logic [7:0] b;
    b = a[7:0];
    isMapped = (a[1:0] == 2'h0) && (b <= usw_pkg::ADDR_IRQ_EN);
    if (ADDR_W > 8)
    begin
      isMapped = isMapped && ((a >> 8) == '0);
    end
  endfunction

  // ****************************************
  // Registers and state
  // ****************************************
  logic [7:0]  txCtrl_r;      // Transmit status/control
  logic [7:0]  rxCtrl_r;      // Receive status/control
  logic [7:0]  baudCtrl_r;    // Baud control
  logic [7:0]  divHi_r;       // Divisor high byte
  logic [7:0]  divLo_r;       // Divisor low byte
  logic [7:0]  odSel_r;       // Open-drain select
  logic [7:0]  txBuf_r;       // Transmit buffer
  logic        txIrqEn_r;     // Transmit flag enable
  logic        txFlag_r;      // Transmit buffer empty flag
  logic        rxFlag_r;      // Wake-up flag
  logic        bufFull_r;     // Buffer holds unsent data
  logic [8:0]  shift_r;       // Shift register, never mapped
  logic [3:0]  bitCnt_r;      // Bit being sent
  usw_pkg::usw_tx_state_e state_r; // Sequencer
  // Bus slave holding state
  logic              awHeld_r; // Write address captured
  logic [ADDR_W-1:0] awAddr_r; // Captured write address
  logic              wHeld_r;  // Write data captured
  logic [7:0]        wData_r;  // Captured low byte
  logic              wLane_r;  // Low byte lane strobe
  // Pin synchronisers, index 0 clock line, 1 data line
  logic [usw_pkg::SYNC_LEN-1:0] sync_r [2];
  logic [1:0]  lineLvl_r;     // Agreed line levels
  logic        dataPrev_r;    // Data level one cycle back

  // ****************************************
  // Decoded controls
  // ****************************************
  logic        masterPath;    // Clocked master owns the pins
  logic        txGo;          // Transmitter allowed to run
  logic        txActive;      // Bit on the wire
  logic        baudTick;      // Half-bit tick
  logic        doWrite;       // Register write this cycle
  logic        wrEn;          // Write with low lane
  logic        txWrite;       // Write to transmit buffer
  logic        rdTake;        // Read address taken
  logic        rdRxBuf;       // Read of receive buffer taken
  logic        wakeArmed;     // Watching for a wake edge
  logic        wakeEdge;      // Falling edge seen
  logic [3:0]  lastIdx;       // Index of final bit
  logic [15:0] divisor;       // Effective divisor
  logic        clkLevel;      // Wanted clock line level
  logic [7:0]  rdByte;        // Read mux output

  assign masterPath = rxCtrl_r[usw_pkg::RXC_SPE]
                      && txCtrl_r[usw_pkg::TXC_SYNC]
                      && txCtrl_r[usw_pkg::TXC_MASTER];
  assign txGo     = masterPath && txCtrl_r[usw_pkg::TXC_EN];
  assign txActive = (state_r == usw_pkg::ST_ACTIVE)
                    || (state_r == usw_pkg::ST_RETURN);
  assign lastIdx  = txCtrl_r[usw_pkg::TXC_NINE] ? usw_pkg::LAST_BIT9
                                                : usw_pkg::LAST_BIT8;
  // Narrow divisor ignores the high byte
  assign divisor  = baudCtrl_r[usw_pkg::BDC_WIDE] ? {divHi_r, divLo_r}
                                                  : {8'h00, divLo_r};

  // ****************************************
  // Baud generator
  // ****************************************
  // Held in restart while asleep, so no tick can arrive
  usw_baud_gen #(
    .DIV_W   (16)
  ) uBaud (
    .ref_clk (ref_clk),
    .rst     (rst),
    .run     (txActive && !sleepMode),
    .divisor (divisor),
    .tick    (baudTick)
  );

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  // A write is held off during the load cycle so that a new byte
  // never lands in the same edge as the buffer move
  assign awready = !awHeld_r && !bvalid;
  assign wready  = !wHeld_r && !bvalid;
  assign doWrite = awHeld_r && wHeld_r && !bvalid
                   && (state_r != usw_pkg::ST_LOAD);
  assign wrEn    = doWrite && wLane_r && isMapped(awAddr_r);
  assign txWrite = wrEn && (awAddr_r[7:0] == usw_pkg::ADDR_TX_BUF);

  // Address and data are taken independently
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
      wHeld_r  <= 1'b0;
      wData_r  <= 8'h00;
      wLane_r  <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awHeld_r <= 1'b1;
        awAddr_r <= awaddr;
      end
      else if (doWrite)
      begin
        awHeld_r <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wHeld_r <= 1'b1;
        wData_r <= wdata[7:0];
        wLane_r <= wstrb[0];
      end
      else if (doWrite)
      begin
        wHeld_r <= 1'b0;
      end
    end
  end

  // Response one cycle after both halves are held
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      bvalid <= 1'b0;
      bresp  <= usw_pkg::RESP_OKAY;
    end
    else if (doWrite)
    begin
      bvalid <= 1'b1;
      bresp  <= isMapped(awAddr_r) ? usw_pkg::RESP_OKAY
                                   : usw_pkg::RESP_SLVE;
    end
    else if (bready)
    begin
      bvalid <= 1'b0;
    end
  end

  // Control registers; read-only bits never stored
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      txCtrl_r   <= usw_pkg::REG_RST;
      rxCtrl_r   <= usw_pkg::REG_RST;
      baudCtrl_r <= usw_pkg::REG_RST;
      divHi_r    <= usw_pkg::REG_RST;
      divLo_r    <= usw_pkg::REG_RST;
      odSel_r    <= usw_pkg::REG_RST;
      txBuf_r    <= usw_pkg::REG_RST;
      txIrqEn_r  <= 1'b0;
    end
    else if (wrEn)
    begin
      case (awAddr_r[7:0])
        usw_pkg::ADDR_TX_CTRL:   txCtrl_r   <= wData_r & usw_pkg::TXC_WMASK;
        usw_pkg::ADDR_RX_CTRL:   rxCtrl_r   <= wData_r & usw_pkg::RXC_WMASK;
        usw_pkg::ADDR_BAUD_CTRL: baudCtrl_r <= wData_r & usw_pkg::BDC_WMASK;
        usw_pkg::ADDR_DIV_HI:    divHi_r    <= wData_r;
        usw_pkg::ADDR_DIV_LO:    divLo_r    <= wData_r;
        usw_pkg::ADDR_OD_SEL:    odSel_r    <= wData_r & usw_pkg::OD_WMASK;
        usw_pkg::ADDR_TX_BUF:    txBuf_r    <= wData_r;
        usw_pkg::ADDR_IRQ_EN:    txIrqEn_r  <= wData_r[usw_pkg::IRQ_TX];
        // Flag status and receive buffer ignore writes
        default:                 txIrqEn_r  <= txIrqEn_r;
      endcase
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  assign arready = !rvalid;
  assign rdTake  = arvalid && arready;
  assign rdRxBuf = rdTake && isMapped(araddr)
                   && (araddr[7:0] == usw_pkg::ADDR_RX_BUF);

  // Read mux; unused bit positions come back zero
  always_comb
  begin
    rdByte = 8'h00;
    case (araddr[7:0])
      usw_pkg::ADDR_TX_CTRL:
      begin
        rdByte = txCtrl_r;
        rdByte[usw_pkg::TXC_EMPTY] = (state_r == usw_pkg::ST_IDLE);
      end
      usw_pkg::ADDR_RX_CTRL:   rdByte = rxCtrl_r;
      usw_pkg::ADDR_BAUD_CTRL: rdByte = baudCtrl_r;
      usw_pkg::ADDR_DIV_HI:    rdByte = divHi_r;
      usw_pkg::ADDR_DIV_LO:    rdByte = divLo_r;
      usw_pkg::ADDR_OD_SEL:    rdByte = odSel_r;
      usw_pkg::ADDR_TX_BUF:    rdByte = txBuf_r;
      usw_pkg::ADDR_IRQ_STAT:
      begin
        rdByte[usw_pkg::IRQ_TX] = txFlag_r;
        rdByte[usw_pkg::IRQ_RX] = rxFlag_r;
      end
      usw_pkg::ADDR_IRQ_EN:    rdByte[usw_pkg::IRQ_TX] = txIrqEn_r;
      // No receive shifter exists; buffer reads zero
      default:                 rdByte = 8'h00;
    endcase
  end

  // Registered read data, held until rready
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= usw_pkg::RESP_OKAY;
    end
    else if (rdTake)
    begin
      rvalid <= 1'b1;
      rdata  <= isMapped(araddr) ? {24'h000000, rdByte} : 32'h0000_0000;
      rresp  <= isMapped(araddr) ? usw_pkg::RESP_OKAY : usw_pkg::RESP_SLVE;
    end
    else if (rready)
    begin
      rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Line synchronisers
  // ****************************************
  // A level counts only once the last two stages agree
  for (genvar i = 0; i < 2; i++)
  begin : gSync
    always_ff @(posedge ref_clk)
    begin
      if (rst)
      begin
        sync_r[i]    <= '1;
        lineLvl_r[i] <= 1'b1;
      end
      else
      begin
        sync_r[i] <= {sync_r[i][usw_pkg::SYNC_LEN-2:0],
                      (i == 0) ? serialClockLineIn : serialDataLineIn};
        if (sync_r[i][1] == sync_r[i][2])
        begin
          lineLvl_r[i] <= sync_r[i][2];
        end
      end
    end
  end

  // ****************************************
  // Wake-up monitor
  // ****************************************
  // Only in the unclocked mode, and never while sending
  assign wakeArmed = rxCtrl_r[usw_pkg::RXC_SPE]
                     && baudCtrl_r[usw_pkg::BDC_WAKE]
                     && !txCtrl_r[usw_pkg::TXC_SYNC]
                     && !txActive;
  assign wakeEdge  = wakeArmed && dataPrev_r && !lineLvl_r[1];

  // Previous level for the edge detector
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      dataPrev_r <= 1'b1;
    end
    else
    begin
      dataPrev_r <= lineLvl_r[1];
    end
  end

  // Edge sets, buffer read clears; set wins. Sampled on ref_clk even
  // in sleep, so the flag still rises with the block frozen
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rxFlag_r <= 1'b0;
    end
    else if (wakeEdge)
    begin
      rxFlag_r <= 1'b1;
    end
    else if (rdRxBuf)
    begin
      rxFlag_r <= 1'b0;
    end
  end

  // ****************************************
  // Transmit sequencer
  // ****************************************
  // Active half drives the clock away from idle, return half
  // brings it back; the slave may sample on the return edge
  always_ff @(posedge ref_clk)
  begin
    if (rst || !txGo)
    begin
      state_r <= usw_pkg::ST_IDLE;
    end
    else if (!sleepMode)
    begin
      case (state_r)
        usw_pkg::ST_IDLE:
          if (bufFull_r && !txWrite)
          begin
            state_r <= usw_pkg::ST_LOAD;
          end
        usw_pkg::ST_LOAD:
          state_r <= usw_pkg::ST_ACTIVE;
        usw_pkg::ST_ACTIVE:
          if (baudTick)
          begin
            state_r <= usw_pkg::ST_RETURN;
          end
        usw_pkg::ST_RETURN:
          if (baudTick)
          begin
            if (bitCnt_r != lastIdx)
            begin
              state_r <= usw_pkg::ST_ACTIVE;
            end
            else if (bufFull_r && !txWrite)
            begin
              state_r <= usw_pkg::ST_LOAD;
            end
            else
            begin
              state_r <= usw_pkg::ST_IDLE;
            end
          end
        default:
          state_r <= usw_pkg::ST_IDLE;
      endcase
    end
  end

  // Shift register and bit counter
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      shift_r  <= 9'h1FF;
      bitCnt_r <= 4'h0;
    end
    else if (state_r == usw_pkg::ST_LOAD)
    begin
      shift_r  <= {txCtrl_r[usw_pkg::TXC_NINE] ? txCtrl_r[usw_pkg::TXC_NINTH]
                                                : 1'b1, txBuf_r};
      bitCnt_r <= 4'h0;
    end
    else if (state_r == usw_pkg::ST_RETURN && baudTick && !sleepMode)
    begin
      shift_r  <= {1'b1, shift_r[8:1]};
      bitCnt_r <= bitCnt_r + 4'h1;
    end
  end

  // Buffer occupancy and its flag; write sets occupancy and clears the flag, load the reverse
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      bufFull_r <= 1'b0;
      txFlag_r  <= usw_pkg::TXF_RST;
    end
    else if (txWrite)
    begin
      bufFull_r <= 1'b1;
      txFlag_r  <= 1'b0;
    end
    else if (state_r == usw_pkg::ST_LOAD)
    begin
      bufFull_r <= 1'b0;
      txFlag_r  <= 1'b1;
    end
  end

  // Enable masks the request, flag untouched
  assign txIrq = txFlag_r && txIrqEn_r;
  assign rxIrq = rxFlag_r;

  // ****************************************
  // Pin drivers
  // ****************************************
  assign clkLevel = (state_r == usw_pkg::ST_ACTIVE)
                    ? !baudCtrl_r[usw_pkg::BDC_POL]
                    : baudCtrl_r[usw_pkg::BDC_POL];

  // Registered drive; open-drain only pulls low
  always_ff @(posedge ref_clk)
  begin
    if (rst || !masterPath)
    begin
      serialClockLineOut  <= 1'b1;
      serialClockLineOe_n <= 1'b1;
      serialDataLineOut   <= 1'b1;
      serialDataLineOe_n  <= 1'b1;
    end
    else if (odSel_r[usw_pkg::OD_LINES])
    begin
      serialClockLineOut  <= 1'b0;
      serialClockLineOe_n <= clkLevel;
      serialDataLineOut   <= 1'b0;
      serialDataLineOe_n  <= !(txActive && !shift_r[0]);
    end
    else
    begin
      serialClockLineOut  <= clkLevel;
      serialClockLineOe_n <= 1'b0;
      serialDataLineOut   <= shift_r[0];
      serialDataLineOe_n  <= !txActive;
    end
  end

endmodule

// ### hw/usw_pkg.sv
/*
  Constants, register map and types for the serial transmit and
  wake-up block. Assumes a 32-bit register bus with byte addresses.
*/
package usw_pkg;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_RX_CTRL   = 8'h00; // Receive status/control
  localparam logic [7:0] ADDR_TX_BUF    = 8'h04; // Transmit buffer
  localparam logic [7:0] ADDR_TX_CTRL   = 8'h08; // Transmit status/control
  localparam logic [7:0] ADDR_BAUD_CTRL = 8'h0C; // Baud control
  localparam logic [7:0] ADDR_DIV_HI    = 8'h10; // Divisor high byte
  localparam logic [7:0] ADDR_DIV_LO    = 8'h14; // Divisor low byte
  localparam logic [7:0] ADDR_OD_SEL    = 8'h18; // Open-drain select
  localparam logic [7:0] ADDR_RX_BUF    = 8'h1C; // Receive buffer
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h20; // Flag status
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h24; // Flag enables

  // ****************************************
  // Field positions
  // ****************************************
  localparam int TXC_MASTER = 7; // Clock source master
  localparam int TXC_NINE   = 6; // Nine-bit transmit enable
  localparam int TXC_EN     = 5; // Transmit enable
  localparam int TXC_SYNC   = 4; // Clocked mode select
  localparam int TXC_EMPTY  = 1; // Shift register empty, read-only
  localparam int TXC_NINTH  = 0; // Ninth data bit
  localparam int RXC_SPE    = 7; // Serial port enable
  localparam int BDC_POL    = 4; // Clock idle polarity
  localparam int BDC_WIDE   = 3; // Wide divisor select
  localparam int BDC_WAKE   = 1; // Wake on edge enable
  localparam int OD_LINES   = 0; // Open-drain for both lines
  localparam int IRQ_TX     = 0; // Transmit flag / enable
  localparam int IRQ_RX     = 1; // Receive flag

  // ****************************************
  // Writable masks and reset values
  // ****************************************
  localparam logic [7:0] TXC_WMASK = 8'hF1;
  localparam logic [7:0] RXC_WMASK = 8'h80;
  localparam logic [7:0] BDC_WMASK = 8'h1A;
  localparam logic [7:0] OD_WMASK  = 8'h03;
  localparam logic [7:0] REG_RST   = 8'h00; // All control bytes
  localparam logic       TXF_RST   = 1'b1;  // Buffer empty at reset

  // ****************************************
  // Frame and bus constants
  // ****************************************
  localparam logic [3:0] LAST_BIT8 = 4'h7; // Index of eighth bit
  localparam logic [3:0] LAST_BIT9 = 4'h8; // Index of ninth bit
  localparam int         SYNC_LEN  = 3;    // Pin synchroniser depth
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVE = 2'h2; // Unmapped address

  // Transmit sequencer, Gray on every step except RETURN to LOAD and ACTIVE to IDLE
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_LOAD   = 2'h1,
    ST_ACTIVE = 2'h3,
    ST_RETURN = 2'h2
  } usw_tx_state_e;

endpackage

// ### hw/usw_baud_gen.sv
/*
  Baud generator: one tick per divisor+1 clocks while running.
  Assumes the caller holds run low to restart the count.
*/
`timescale 1ns/1ps
module usw_baud_gen #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Control
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] divisor,
  // Half-bit tick
  output logic                  tick
);

  // ****************************************
  // Parameter check
  // ****************************************
  if (DIV_W < 8 || DIV_W > 16)
  begin : gBadWidth
    $error("DIV_W must be 8 to 16");
  end

  logic [DIV_W-1:0] count_r; // Clocks into this half bit

  // Tick when the count reaches the divisor
  assign tick = run && (count_r == divisor);

  // Counter restarts whenever run drops
  always_ff @(posedge ref_clk)
  begin
    if (rst || !run || tick)
    begin
      count_r <= '0;
    end
    else
    begin
      count_r <= count_r + 1'b1;
    end
  end

endmodule

// ### verif/usw_monitor.sv
/* Port checker for usw_top. Assumes the bind below and one clock. */
`timescale 1ns/1ps
module usw_monitor #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              rst,
  // Watched ports
  input wire logic              sleepMode,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [31:0]       rdata,
  input wire logic              rvalid,
  input wire logic              serialClockLineOut,
  input wire logic              serialClockLineOe_n,
  input wire logic              serialDataLineIn,
  input wire logic              serialDataLineOut,
  input wire logic              serialDataLineOe_n,
  input wire logic              rxIrq
);
  // ****
  // Pin, flag and read data relations
  // ****
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_sleep_frozen:
    assert property (sleepMode[*3] |-> $stable(serialClockLineOut) && $stable(serialDataLineOut))
      else $error("pin moved asleep");
  chk_wake_edge:
    assert property ($rose(rxIrq) |-> !$past(serialDataLineIn, 3)) else $error("wake no fall");
  chk_wake_halfdup:
    assert property ($rose(rxIrq) |-> serialDataLineOe_n) else $error("wake while sending");
  chk_rxbuf_clear:
    assert property (arvalid && arready && araddr == usw_pkg::ADDR_RX_BUF |=> !rxIrq)
      else $error("wake flag kept");
  chk_data_pins:
    assert property (!serialDataLineOe_n |-> !serialClockLineOe_n || !serialDataLineOut)
      else $error("data without clock");
  // Idle level must hold while no bit is on the line
  chk_clock_idle:
    assert property (serialDataLineOe_n && !serialClockLineOe_n && $past(!serialClockLineOe_n)
      |-> $stable(serialClockLineOut)) else $error("idle clock moved");
  chk_bit_edges:
    assert property (!serialDataLineOe_n && $past(!serialDataLineOe_n)
      && $changed(serialDataLineOut) |-> $changed(serialClockLineOut)) else $error("bit skew");
  chk_rdata_upper:
    assert property (rvalid |-> rdata[31:8] == 24'h000000) else $error("upper bits set");
  cover property ($rose(rxIrq));
  cover property ($fell(serialDataLineOe_n));
  cover property (sleepMode && !serialDataLineOe_n);
endmodule
bind usw_top usw_monitor #(.ADDR_W(ADDR_W)) i_usw_monitor (
  .ref_clk(ref_clk), .rst(rst), .sleepMode(sleepMode), .araddr(araddr),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rxIrq(rxIrq),
  .serialClockLineOut(serialClockLineOut), .serialClockLineOe_n(serialClockLineOe_n),
  .serialDataLineIn(serialDataLineIn), .serialDataLineOut(serialDataLineOut),
  .serialDataLineOe_n(serialDataLineOe_n));

// ### verif/usw_slave_model.sv
/* Passive clocked serial slave. Assumes resolved line levels. */
`timescale 1ns/1ps
module usw_slave_model (
  // Resolved lines
  input wire logic lineCk,
  input wire logic lineDat,
  // Idle level and clear
  input wire logic idleLvl,
  input wire logic clr,
  // Bits seen, first at index 0
  output logic [31:0] bits,
  output int          nBits
);
  // Sample on return to idle, the data is held the whole bit
  always @(lineCk or posedge clr)
  begin
    if (clr)
    begin
      bits = 32'h00000000;
      nBits = 0;
    end
    else if (lineCk === idleLvl && nBits < 32)
    begin
      bits[nBits] = lineDat;
      nBits++;
    end
  end
endmodule

// ### verif/testbench.sv
/* Bench for usw_top. Assumes pull-ups on both lines. */
`timescale 1ns/1ps
module testbench;
  logic ref_clk, rst, sleepMode, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, txIrq, rxIrq;
  logic ckOut, ckOe_n, datOut, datOe_n, extDat, idleLvl, clr;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d, bits;
  logic [1:0]  bresp, rresp, r;
  int          nBits, num_errors, n_compared;
  wire         ckW = ckOe_n ? 1'b1 : ckOut; // Pulled up when released
  wire         datW = datOe_n ? extDat : datOut;
  // Address, write, read, reset value, response
  logic [39:0] rows [11] = '{40'h14_13_13_00_00, 40'h10_FF_FF_00_00, 40'h0C_FF_1A_00_00,
    40'h18_FF_03_00_00, 40'h00_FF_80_00_00, 40'h08_0F_03_02_00, 40'h20_FF_01_01_00,
    40'h04_5A_5A_00_00, 40'h1C_FF_00_00_00, 40'h24_FF_01_00_00, 40'h28_FF_00_00_02};
  usw_top i_usw_top (
    .ref_clk(ref_clk), .rst(rst), .sleepMode(sleepMode), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .serialClockLineIn(ckW), .serialClockLineOut(ckOut),
    .serialClockLineOe_n(ckOe_n), .serialDataLineIn(datW), .serialDataLineOut(datOut),
    .serialDataLineOe_n(datOe_n), .txIrq(txIrq), .rxIrq(rxIrq));
  usw_slave_model i_usw_slave_model (.lineCk(ckW), .lineDat(datW), .idleLvl(idleLvl),
    .clr(clr), .bits(bits), .nBits(nBits));
  // ****
  // Tasks
  // ****
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // One access; ready is taken at the edge, seen at the negedge before it
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
    logic ta, tw, tb;
    @(posedge ref_clk);
    awaddr <= a;
    araddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge ref_clk);
      ta = (awvalid & awready) | (arvalid & arready);
      tw = wvalid & wready;
      tb = w ? bvalid : rvalid;
      d = rdata;
      r = w ? bresp : rresp;
      @(posedge ref_clk);
      if (ta) awvalid <= 1'b0;
      if (ta) arvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
      if (tb) rready <= 1'b0;
    end
  endtask
  task automatic clear(input logic lvl);
    // Let a newly driven clock settle so it is not taken as a bit
    @(posedge ref_clk);
    idleLvl <= lvl;
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
  endtask
  task automatic pulse;
    rst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
  endtask
  task automatic test_done;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Watchdog, far above the 1300 or so cycles needed
  initial
  begin
    #60000;
    num_errors++;
    test_done;
  end
  initial
  begin
    {rst, sleepMode, awvalid, wvalid, bready, arvalid, rready, clr, idleLvl} = 9'h100;
    {awaddr, araddr, wdata, extDat} = 49'h1;
    num_errors = 0;
    n_compared = 0;
    pulse;
    foreach (rows[i])
    begin
      acc(1'b1, rows[i][39:32], rows[i][31:24]);
      cmp("bresp", 32'(rows[i][7:0]), 32'(r));
      acc(1'b0, rows[i][39:32], 8'h00);
      cmp("rdata", 32'(rows[i][23:16]), d);
      cmp("rresp", 32'(rows[i][7:0]), 32'(r));
    end
    pulse;
    foreach (rows[i])
    begin
      acc(1'b0, rows[i][39:32], 8'h00);
      cmp("reset", 32'(rows[i][15:8]), d);
    end
    cmp("txIrq", 32'(txIrq), 32'h0);
    // Divisor 19 gives 20 clocks a half bit, a 160 ns link clock
    acc(1'b1, 8'h14, 8'h13);
    acc(1'b1, 8'h00, 8'h80);
    acc(1'b1, 8'h08, 8'h90);
    acc(1'b1, 8'h24, 8'h01);
    acc(1'b1, 8'h08, 8'hF1);
    clear(1'b0);
    cmp("idle", 32'(ckW), 32'h0);
    acc(1'b1, 8'h04, 8'hA5);
    repeat (2) @(posedge ref_clk);
    cmp("txIrq", 32'(txIrq), 32'h1);
    acc(1'b1, 8'h04, 8'h3C);
    cmp("txIrq", 32'(txIrq), 32'h0);
    acc(1'b0, 8'h08, 8'h00);
    cmp("empty", d, 32'h000000F1);
    // Sleep in mid-word must lose no bit
    sleepMode <= 1'b1;
    repeat (60) @(posedge ref_clk);
    sleepMode <= 1'b0;
    for (int i = 0; i < 3000 && nBits < 18; i++) @(posedge ref_clk);
    cmp("frame", bits, {14'h0000, 1'b1, 8'h3C, 1'b1, 8'hA5});
    cmp("txIrq", 32'(txIrq), 32'h1);
    repeat (30) @(posedge ref_clk);
    acc(1'b0, 8'h08, 8'h00);
    cmp("empty", d, 32'h000000F3);
    acc(1'b1, 8'h08, 8'h00);
    acc(1'b1, 8'h0C, 8'h10);
    // Third word goes out on open-drain lines
    acc(1'b1, 8'h18, 8'h01);
    acc(1'b1, 8'h08, 8'h90);
    acc(1'b1, 8'h08, 8'hB0);
    clear(1'b1);
    cmp("idle", 32'(ckW), 32'h1);
    acc(1'b1, 8'h04, 8'h81);
    for (int i = 0; i < 2000 && nBits < 8; i++) @(posedge ref_clk);
    cmp("byte", bits, 32'h00000081);
    acc(1'b1, 8'h08, 8'h00);
    acc(1'b1, 8'h0C, 8'h02);
    extDat <= 1'b0;
    for (int i = 0; i < 20 && rxIrq !== 1'b1; i++) @(posedge ref_clk);
    cmp("rxIrq", 32'(rxIrq), 32'h1);
    acc(1'b0, 8'h1C, 8'h00);
    cmp("rxIrq", 32'(rxIrq), 32'h0);
    test_done;
  end
endmodule
